// *** logic/afbi_pkg.sv ***
`default_nettype none
package afbi_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned T_ACC_NS = 75;
  localparam int unsigned T_PAGE_NS = 25;
  localparam int unsigned T_WP_NS = 60;
  localparam int unsigned T_WH_NS = 30;
  localparam int unsigned T_RST_LOW_NS = 25000;
  localparam int unsigned T_RST_REC_NS = 210;
  localparam int unsigned CYC_ACC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_PAGE = (T_PAGE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_WP = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_WH = (T_WH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_RST_LOW = (T_RST_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYC_RST_REC = (T_RST_REC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 16;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_OP = 1;
  localparam int unsigned CFG_BYTE = 0;
  localparam int unsigned CFG_KEEP = 1;
  localparam int unsigned CFG_SINGLE = 2;
  localparam logic [2:0] CFG_RST = 3'h0;
  // ==========================================================
  // device commands and page configuration
  localparam logic [15:0] CMD_SET_CFG = 16'h0060;
  localparam logic [15:0] CMD_CFG_CONFIRM = 16'h0004;
  localparam logic [15:0] CMD_CLR_STATUS = 16'h0050;
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
  localparam int unsigned PCFG_PAGE8 = 13;
  localparam int unsigned PAGE4_LSB = 3;
  localparam int unsigned PAGE8_LSB = 4;
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_PAGE_CFG = 2'h2,
    OP_RESET = 2'h3
  } afbi_op_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dq;
    logic dq_oe;
    logic chip_select_a;
    logic chip_select_b;
    logic chip_select_c;
    logic output_enable_n;
    logic write_enable_n;
    logic reset_powerdown_n;
    logic byte_width_n;
  } afbi_pins_t;
endpackage
`default_nettype wire

// *** logic/afbi_host.sv ***
// Function
// - single device: c and b tied low, chip_select_a alone selects.
// - read: select, assert output_enable_n, keep write and reset deasserted.
// - issue read-array command before page reads after other operations; the host issues it only at the end of page config, not after writes.
// - page config: writes 0060h then 0004h, value on address 15..0.
// - host writes zeros to reserved page configuration bits.
// - eight-word mode needs clear-status after page configuration.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module afbi_host
  import afbi_pkg::*;
#(
  parameter int unsigned RST_LOW_CYC = CYC_RST_LOW
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // flash pins
  output afbi_pins_t flash_o,
  input wire logic [15:0] dq_i
);
  // ==========================================================
  // reset release
  logic rst_m_q;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_m_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n <= rst_m_q;
    end
  end

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SETUP = 8'h02,
    S_RD_WAIT = 8'h04,
    S_WR_PULSE = 8'h08,
    S_WR_HOLD = 8'h10,
    S_DESEL = 8'h20,
    S_RST_LOW = 8'h40,
    S_RST_REC = 8'h80
  } afbi_state_t;

  afbi_state_t state_q;
  afbi_op_t op_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [2:0] cfg_q;
  logic [1:0] step_q;
  logic [CNT_W-1:0] cnt_q;
  logic page8_q;
  logic page_valid_q;
  logic [23:0] page_addr_q;
  logic busy;
  logic go;
  afbi_op_t go_op;
  logic page_hit;
  logic [23:0] page_mask;
  logic [15:0] step_data;
  logic [23:0] step_addr;

  // ==========================================================
  // apb registers
  assign busy = (state_q != S_IDLE);
  assign pready_o = 1'b1;
  assign go = psel_i && penable_i && pwrite_i && (paddr_i == OFS_CTRL)
    && pwdata_i[CTRL_GO] && !busy;
  // op arrives in the same access as go, so decode it from the bus
  assign go_op = afbi_op_t'(pwdata_i[CTRL_OP +: 2]);

  always_comb
  begin
    prdata_o = 32'h0000_0000;
    pslverr_o = 1'b0;
    case (paddr_i)
      OFS_CTRL: prdata_o = {29'h0, op_q, busy};
      OFS_ADDR: prdata_o = {8'h00, addr_q};
      OFS_WDATA: prdata_o = {16'h0000, wdata_q};
      OFS_RDATA: prdata_o = {16'h0000, rdata_q};
      OFS_CFG: prdata_o = {29'h0, cfg_q};
      OFS_STAT: prdata_o = {28'h0, !flash_o.chip_select_a, page_valid_q, page8_q, busy};
      default: pslverr_o = psel_i && penable_i;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= 24'h00_0000;
      wdata_q <= 16'h0000;
      cfg_q <= CFG_RST;
      op_q <= OP_READ;
    end
    else if (psel_i && penable_i && pwrite_i && !busy)
    begin
      case (paddr_i)
        OFS_CTRL: op_q <= afbi_op_t'(pwdata_i[CTRL_OP +: 2]);
        OFS_ADDR: addr_q <= pwdata_i[23:0];
        OFS_WDATA: wdata_q <= pwdata_i[15:0];
        OFS_CFG: cfg_q <= pwdata_i[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // page tracking
  // in-page bits follow the page length
  assign page_mask = page8_q ? ~24'h00_000f : ~24'h00_0007;
  // buffer hit only while still selected in the same page
  assign page_hit = page_valid_q && !flash_o.chip_select_a && !cfg_q[CFG_SINGLE]
    && ((addr_q & page_mask) == (page_addr_q & page_mask));

  always_comb
  begin
    // only the page length bit may be set
    step_addr = {8'h00, 16'h0000};
    step_addr[PCFG_PAGE8] = addr_q[PCFG_PAGE8];
    case (step_q)
      2'h0: step_data = CMD_SET_CFG;
      2'h1: step_data = CMD_CFG_CONFIRM;
      2'h2: step_data = CMD_CLR_STATUS;
      default: step_data = CMD_READ_ARRAY;
    endcase
    if (op_q != OP_PAGE_CFG)
    begin
      step_addr = addr_q;
      step_data = wdata_q;
    end
  end

  // ==========================================================
  // bus sequencer
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      step_q <= 2'h0;
      cnt_q <= '0;
      rdata_q <= 16'h0000;
      page8_q <= 1'b0;
      page_valid_q <= 1'b0;
      page_addr_q <= 24'h00_0000;
      flash_o <= '{addr: 24'h00_0000, dq: 16'h0000, dq_oe: 1'b0,
        chip_select_a: 1'b1, chip_select_b: 1'b0, chip_select_c: 1'b0,
        output_enable_n: 1'b1, write_enable_n: 1'b1,
        reset_powerdown_n: 1'b1, byte_width_n: 1'b1};
    end
    else
    begin
      flash_o.byte_width_n <= !cfg_q[CFG_BYTE];
      // c and b held low, chip_select_a alone selects
      flash_o.chip_select_b <= 1'b0;
      flash_o.chip_select_c <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          step_q <= 2'h0;
          if (go)
          begin
            state_q <= (go_op == OP_RESET) ? S_RST_LOW : S_SETUP;
            cnt_q <= '0;
            if (go_op == OP_RESET)
            begin
              flash_o.chip_select_a <= 1'b1;
              flash_o.reset_powerdown_n <= 1'b0;
            end
          end
        end
        S_SETUP:
        begin
          flash_o.addr <= step_addr;
          cnt_q <= '0;
          // all chip selects low selects the device
          flash_o.chip_select_a <= 1'b0;
          if (op_q == OP_READ)
          begin
            // read with write enable and reset deasserted
            flash_o.output_enable_n <= 1'b0;
            flash_o.write_enable_n <= 1'b1;
            flash_o.dq_oe <= 1'b0;
            state_q <= S_RD_WAIT;
          end
          else
          begin
            // output enable kept high so the cycle is a write
            flash_o.output_enable_n <= 1'b1;
            flash_o.dq <= step_data;
            flash_o.dq_oe <= 1'b1;
            flash_o.write_enable_n <= 1'b0;
            page_valid_q <= 1'b0;
            state_q <= S_WR_PULSE;
          end
        end
        S_RD_WAIT:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q + 1'b1 >= (page_hit ? CNT_W'(CYC_PAGE) : CNT_W'(CYC_ACC)))
          begin
            rdata_q <= cfg_q[CFG_BYTE] ? {8'h00, dq_i[7:0]} : dq_i;
            flash_o.output_enable_n <= 1'b1;
            page_valid_q <= 1'b1;
            page_addr_q <= flash_o.addr;
            if (cfg_q[CFG_KEEP])
            begin
              state_q <= S_IDLE;
            end
            else
            begin
              state_q <= S_DESEL;
            end
          end
        end
        S_WR_PULSE:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q + 1'b1 >= CNT_W'(CYC_WP))
          begin
            // rising write enable latches address and data
            flash_o.write_enable_n <= 1'b1;
            cnt_q <= '0;
            state_q <= S_WR_HOLD;
          end
        end
        S_WR_HOLD:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q + 1'b1 >= CNT_W'(CYC_WH))
          begin
            state_q <= S_DESEL;
            if (op_q == OP_PAGE_CFG && step_q != 2'h3)
            begin
              state_q <= S_SETUP;
              step_q <= (step_q == 2'h1 && !addr_q[PCFG_PAGE8]) ? 2'h3 : step_q + 2'h1;
            end
            else if (op_q == OP_PAGE_CFG)
            begin
              // page length now follows bit 13
              page8_q <= addr_q[PCFG_PAGE8];
            end
          end
        end
        S_DESEL:
        begin
          flash_o.dq_oe <= 1'b0;
          flash_o.chip_select_a <= 1'b1;
          page_valid_q <= 1'b0;
          state_q <= S_IDLE;
        end
        S_RST_LOW:
        begin
          cnt_q <= cnt_q + 1'b1;
          page_valid_q <= 1'b0;
          page8_q <= 1'b0;
          if (cnt_q + 1'b1 >= CNT_W'(RST_LOW_CYC))
          begin
            flash_o.reset_powerdown_n <= 1'b1;
            cnt_q <= '0;
            state_q <= S_RST_REC;
          end
        end
        S_RST_REC:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q + 1'b1 >= CNT_W'(CYC_RST_REC))
          begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/afbi_host_props.sv ***
`default_nettype none
module afbi_host_props
  import afbi_pkg::*;
#(
  parameter int unsigned RST_LOW_CYC = CYC_RST_LOW
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // flash pins
  input wire afbi_pins_t flash_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel, oe_n, we_n, rp_n;
  logic [15:0] low_q;
  assign oe_n = flash_o.output_enable_n;
  assign we_n = flash_o.write_enable_n;
  assign rp_n = flash_o.reset_powerdown_n;
  assign sel = flash_o.chip_select_c ? !(flash_o.chip_select_b && flash_o.chip_select_a)
    : !flash_o.chip_select_b && !flash_o.chip_select_a;
  // edges seen with power-down held low
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i) low_q <= 16'h0;
    else low_q <= rp_n ? 16'h0 : low_q + 16'h1;
  // ====================
  // pin protocol
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_bc_tied: assert property (!flash_o.chip_select_b && !flash_o.chip_select_c)
    else $error("chip select b or c high");
  a_read_sel: assert property (!oe_n |-> sel && !flash_o.dq_oe)
    else $error("read without select or with host driving");
  a_read_quiet: assert property (!oe_n |-> we_n && rp_n)
    else $error("write or reset active in read");
  a_write_sel: assert property (!we_n |-> sel && oe_n && flash_o.dq_oe)
    else $error("write enable without select or data");
  a_write_len: assert property ($fell(we_n) |-> !we_n [*8])
    else $error("write pulse too short");
  a_latch_held: assert property ($rose(we_n) |->
    flash_o.dq_oe && $stable(flash_o.dq) && $stable(flash_o.addr))
    else $error("data or address moved at write latch");
  a_read_addr: assert property (!oe_n && !$past(oe_n) |-> $stable(flash_o.addr))
    else $error("address moved during read");
  a_rst_len: assert property ($rose(rp_n) |->
    low_q + 16'h1 >= RST_LOW_CYC && low_q <= RST_LOW_CYC + 1)
    else $error("power-down pulse length wrong");
  c_read: cover property (!oe_n);
  c_write: cover property ($rose(we_n));
  c_reset: cover property ($rose(rp_n));
endmodule
bind afbi_host afbi_host_props #(.RST_LOW_CYC(RST_LOW_CYC)) i_afbi_host_props (
  .sys_clk_i, .rst_n_i, .flash_o);
`default_nettype wire

// *** bench/afbi_flash_model.sv ***
`default_nettype none
module afbi_flash_model
  import afbi_pkg::*;
(
  // clock and pins
  input wire logic sys_clk_i,
  input wire afbi_pins_t pins_i,
  // resolved data bus
  output logic [15:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sel, sel_q, we_q, drv;
  logic set_q = 1'b0, stat_q = 1'b0;
  logic [15:0] cfg_q = 16'h0, last_q = 16'h0, w;
  logic [23:0] a_q;
  int sh, wait_q = 0;
  assign sel = pins_i.chip_select_c ? !(pins_i.chip_select_b && pins_i.chip_select_a)
    : !pins_i.chip_select_b && !pins_i.chip_select_a;
  assign sh = cfg_q[13] ? 4 : 3;
  // word by address, status reads 0080h
  assign w = stat_q ? 16'h0080 : pins_i.addr[16:1] ^ 16'ha5c3;
  // drive only when selected, reading and sensed
  assign drv = sel && !pins_i.output_enable_n && pins_i.reset_powerdown_n && wait_q == 0;
  // byte bus on low lines; a released line shows the inverse
  assign bus_o = pins_i.dq_oe ? pins_i.dq : !drv ? ~last_q : pins_i.byte_width_n ? w
    : {~last_q[15:8], pins_i.addr[0] ? w[15:8] : w[7:0]};
  always @(posedge sys_clk_i)
  begin
    we_q <= pins_i.write_enable_n;
    sel_q <= sel;
    a_q <= pins_i.addr;
    last_q <= bus_o;
    // new page, register read or reselect senses anew
    if (sel && (!sel_q || (a_q >> sh) != (pins_i.addr >> sh) || stat_q && a_q != pins_i.addr))
      wait_q <= CYC_ACC - 2;
    else if (a_q != pins_i.addr)
      wait_q <= wait_q > CYC_PAGE - 2 ? wait_q : CYC_PAGE - 2;
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
    // power-down clears configuration and read mode
    if (!pins_i.reset_powerdown_n)
    begin
      cfg_q <= 16'h0;
      set_q <= 1'b0;
      stat_q <= 1'b0;
    end
    // latch on rising write enable, output enable wins
    else if (sel && pins_i.write_enable_n && !we_q && pins_i.output_enable_n)
    begin
      if (set_q && pins_i.dq == CMD_CFG_CONFIRM)
        cfg_q <= pins_i.addr[15:0];
      set_q <= !set_q && pins_i.dq == CMD_SET_CFG;
      stat_q <= pins_i.dq == 16'h0070 || stat_q && pins_i.dq != CMD_READ_ARRAY && !set_q;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_afbi_host.sv ***
`default_nettype none
module tb_afbi_host;
  import afbi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pready_o, pslverr_o, er;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [15:0] dq_i;
  logic [23:0] a;
  afbi_pins_t flash_o;
  int errors = 0, n_tests = 0, cyc = 0, bm = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  afbi_host #(.RST_LOW_CYC(20)) i_afbi_host (.sys_clk_i, .rst_n_i, .paddr_i, .psel_i,
    .penable_i, .pwrite_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .flash_o, .dq_i);
  afbi_flash_model i_afbi_flash_model (.sys_clk_i, .pins_i(flash_o), .bus_o(dq_i));
  task close_out();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    paddr_i <= ad;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task op(input logic [1:0] o, input logic [23:0] ad, input logic [15:0] d);
    apb(1'b1, OFS_ADDR, {8'h00, ad});
    apb(1'b1, OFS_WDATA, {16'h0, d});
    apb(1'b1, OFS_CTRL, {29'h0, o, 1'b1});
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, OFS_STAT, 32'h0);
  endtask
  task rd_chk(input logic [23:0] ad, input int st);
    logic [15:0] w;
    w = st ? 16'h0080 : ad[16:1] ^ 16'ha5c3;
    op(OP_READ, ad, 16'h0);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("rdata", bm ? {24'h0, ad[0] ? w[15:8] : w[7:0]} : {16'h0, w}, rd);
  endtask
  task walk(input logic [23:0] msk);
    for (int k = 0; k < 4; k++)
    begin
      a = 24'($urandom) & msk;
      rd_chk(a, 0);
      rd_chk(a ^ 24'h6, 0);
      rd_chk(a ^ 24'h8, 0);
    end
  endtask
  initial
  begin
    void'($urandom(8));
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg", {29'h0, CFG_RST}, rd);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, OFS_CFG, 32'h2);
    walk(24'hfffffe);
    apb(1'b0, OFS_STAT, 32'h0);
    chk("stat", 32'hc, rd);
    apb(1'b0, OFS_ADDR, 32'h0);
    chk("addr", {8'h0, a ^ 24'h8}, rd);
    op(OP_PAGE_CFG, 24'h3fff, 16'h0);
    chk("pcfg", 32'h2000, {16'h0, i_afbi_flash_model.cfg_q});
    apb(1'b0, OFS_STAT, 32'h0);
    chk("page8", 32'h1, {31'h0, rd[1]});
    walk(24'hfffffe);
    apb(1'b1, OFS_CFG, 32'h3);
    bm = 1;
    walk(24'hffffff);
    chk("byte pin", 32'h0, {31'h0, flash_o.byte_width_n});
    bm = 0;
    apb(1'b1, OFS_CFG, 32'h6);
    op(OP_WRITE, 24'h0, 16'h0070);
    rd_chk(24'h10, 1);
    rd_chk(24'h12, 1);
    op(OP_WRITE, 24'h0, CMD_READ_ARRAY);
    op(OP_RESET, 24'h0, 16'h0);
    chk("pcfg", 32'h0, {16'h0, i_afbi_flash_model.cfg_q});
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", {29'h0, OP_RESET, 1'b0}, rd);
    apb(1'b1, OFS_CFG, 32'h2);
    walk(24'hfffffe);
    op(OP_PAGE_CFG, 24'h1fff, 16'h0);
    chk("pcfg", 32'h0, {16'h0, i_afbi_flash_model.cfg_q});
    apb(1'b0, OFS_STAT, 32'h0);
    chk("page8", 32'h0, {31'h0, rd[1]});
    walk(24'hfffffe);
    close_out();
  end
endmodule
`default_nettype wire
